// File: inc/tem_regs.svh
// Constants for the thread event monitor gateway
`ifndef TEM_REGS_SVH
`define TEM_REGS_SVH
`define TEM_THREADS 8
`define TEM_TID_W 3
`define TEM_EVID_W 8
`define TEM_TMO_W 16
`define TEM_WB_TIMEOUT 32'h0000_0000
`define TEM_WB_EVENT 32'h0000_0001
`define TEM_CLK_PERIOD_NS 5
`endif

// File: inc/tem_pkg.sv
// Types for the thread event monitor gateway
`include "tem_regs.svh"
package tem_pkg;
    typedef enum logic [2:0] {
        TEM_OP_NONE = 3'h0,
        TEM_OP_WATCH = 3'h1,
        TEM_OP_WAIT = 3'h2,
        TEM_OP_SIGNAL = 3'h3,
        TEM_OP_CANCEL = 3'h4,
        TEM_OP_END = 3'h5
    } tem_op_t;
    typedef logic [`TEM_TID_W-1:0] tem_tid_t;
    typedef logic [`TEM_EVID_W-1:0] tem_evid_t;
    typedef logic [`TEM_TMO_W-1:0] tem_tmo_t;
endpackage

// File: rtl/tem_thread_slot.sv
// One thread's monitor slot: watch id, flags, timeout counter
`timescale 1ns/1ps
module tem_thread_slot
    import tem_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Per-slot controls from the gateway
    input wire logic i_watch,
    input wire logic i_cancel,
    input wire logic i_wait,
    input wire logic i_preempt,
    input wire logic i_bcast,
    input wire tem_pkg::tem_evid_t i_evid,
    input wire tem_pkg::tem_tmo_t i_tmo,
    input wire logic i_grant,
    // Slot state
    output logic o_hit,
    output logic o_timed_out
);
    logic mon_q;
    logic rec_q;
    logic pend_q;
    tem_evid_t id_q;
    tem_tmo_t cnt_q;
    wire match = mon_q && i_bcast && (i_evid == id_q);
    wire timeup = pend_q && (cnt_q == '0);

    // Event hit wins priority over timeout unless preempted
    assign o_hit = pend_q && (rec_q || match) && !i_preempt;
    assign o_timed_out = pend_q && (i_preempt || timeup) && !o_hit;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mon_q <= 1'b0;
            rec_q <= 1'b0;
            pend_q <= 1'b0;
            id_q <= '0;
            cnt_q <= '0;
        end else if (i_cancel) begin
            mon_q <= 1'b0;
            rec_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            if (i_watch) begin
                mon_q <= 1'b1;
                id_q <= i_evid;
                rec_q <= 1'b0;
            end else if (match) begin
                rec_q <= 1'b1;
            end
            if (i_wait) begin
                pend_q <= 1'b1;
                cnt_q <= i_tmo;
            end else if (pend_q && i_grant) begin
                pend_q <= 1'b0;
                rec_q <= 1'b0;
            end else if (pend_q && cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// File: rtl/tem_gateway.sv
// Event monitor part of the thread message gateway
`timescale 1ns/1ps
// Contract
// - Watch request starts monitoring the given event
// - Event while not waiting is recorded silently
// - Wait sleeps until event or timeout
// - Writeback 0 on timeout, 1 on event
// - Preemption ends waits as timeout
// - Signal broadcast to all gateways, including self
// - Broadcast records and answers waiting monitors; in a cycle with a watch message it is compared with the watch's event id
// - Wait after recorded event answers at once
// - Monitoring continues after an event response
// - Repeated events collapse into one record
// - Cancel stops the thread's monitoring
// - Thread end clears monitoring too
// - Signals reach threads machine-wide
// - Threads tracked until end, then released
module tem_gateway
    import tem_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Messages from execution unit threads
    input wire logic i_msg_valid,
    input wire tem_pkg::tem_op_t i_msg_op,
    input wire tem_pkg::tem_tid_t i_msg_tid,
    input wire tem_pkg::tem_evid_t i_msg_evid,
    input wire tem_pkg::tem_tmo_t i_msg_tmo,
    // Dispatch of new threads
    input wire logic i_dispatch,
    input wire tem_pkg::tem_tid_t i_dispatch_tid,
    // Preemption of the running context
    input wire logic i_preempt,
    // Broadcast network, outbound and inbound
    output logic o_bcast_valid,
    output tem_pkg::tem_evid_t o_bcast_evid,
    input wire logic i_bcast_valid,
    input wire tem_pkg::tem_evid_t i_bcast_evid,
    // Writeback to waiting threads
    output logic o_wb_valid,
    output tem_pkg::tem_tid_t o_wb_tid,
    output logic [31:0] o_wb_data,
    // Thread tracking
    output logic [`TEM_THREADS-1:0] o_active,
    output logic o_release_valid,
    output tem_pkg::tem_tid_t o_release_tid
);
    import tem_pkg::*;

    // ==========================================
    // Message decode
    wire is_watch = i_msg_valid && (i_msg_op == TEM_OP_WATCH);
    wire is_wait = i_msg_valid && (i_msg_op == TEM_OP_WAIT);
    wire is_signal = i_msg_valid && (i_msg_op == TEM_OP_SIGNAL);
    wire is_cancel = i_msg_valid && (i_msg_op == TEM_OP_CANCEL);
    wire is_end = i_msg_valid && (i_msg_op == TEM_OP_END);

    logic [`TEM_THREADS-1:0] hit;
    logic [`TEM_THREADS-1:0] tmo;
    logic [`TEM_THREADS-1:0] grant;
    logic [`TEM_THREADS-1:0] done;
    logic [`TEM_THREADS-1:0] act_q;

    // ==========================================
    // Per-thread slots
    genvar g;
    generate
        for (g = 0; g < `TEM_THREADS; g++) begin : g_slot
            wire sel = (i_msg_tid == tem_tid_t'(g));
            tem_thread_slot u_slot (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_watch(is_watch && sel),
                .i_cancel((is_cancel || is_end) && sel),
                .i_wait(is_wait && sel),
                .i_preempt(i_preempt),
                .i_bcast(i_bcast_valid),
                .i_evid(is_watch ? i_msg_evid : i_bcast_evid),
                .i_tmo(i_msg_tmo),
                .i_grant(grant[g]),
                .o_hit(hit[g]),
                .o_timed_out(tmo[g])
            );
        end
    endgenerate

    // ==========================================
    // One writeback per cycle; lowest thread first
    // Others stay pending; hits and count timeouts are served in later cycles, preemption timeouts only while i_preempt holds
    assign done = hit | tmo;
    assign grant = done & (~done + 1'b1);
    wire any = |done;
    tem_tid_t gtid;
    always_comb begin
        gtid = '0;
        for (int i = `TEM_THREADS - 1; i >= 0; i--) begin
            if (grant[i]) begin
                gtid = i[`TEM_TID_W-1:0];
            end
        end
    end
    wire grant_hit = |(grant & hit);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_wb_valid <= 1'b0;
            o_wb_tid <= '0;
            o_wb_data <= '0;
        end else begin
            o_wb_valid <= any;
            o_wb_tid <= gtid;
            o_wb_data <= grant_hit ? `TEM_WB_EVENT : `TEM_WB_TIMEOUT;
        end
    end

    // ==========================================
    // Signal goes to the fabric, which loops it back here too
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_bcast_valid <= 1'b0;
            o_bcast_evid <= '0;
        end else begin
            o_bcast_valid <= is_signal;
            o_bcast_evid <= i_msg_evid;
        end
    end

    // ==========================================
    // Thread lifecycle tracking
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            act_q <= '0;
            o_release_valid <= 1'b0;
            o_release_tid <= '0;
        end else begin
            for (int i = 0; i < `TEM_THREADS; i++) begin
                if (is_end && i_msg_tid == i[`TEM_TID_W-1:0]) begin
                    act_q[i] <= 1'b0;
                end else if (i_dispatch &&
                             i_dispatch_tid == i[`TEM_TID_W-1:0]) begin
                    act_q[i] <= 1'b1;
                end
            end
            o_release_valid <= is_end;
            o_release_tid <= i_msg_tid;
        end
    end
    assign o_active = act_q;

    // ==========================================
    // Checks
    property p_signal_out;
        @(posedge i_ref_clk) disable iff (i_rst)
        is_signal |=> o_bcast_valid && o_bcast_evid == $past(i_msg_evid);
    endproperty
    a_signal_out: assert property (p_signal_out)
        else $error("signal not broadcast");

    property p_preempt_timeout;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_preempt && any |=> o_wb_valid && o_wb_data == `TEM_WB_TIMEOUT;
    endproperty
    a_preempt_timeout: assert property (p_preempt_timeout)
        else $error("preemption answered as event");

    property p_wb_values;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wb_valid |-> o_wb_data == `TEM_WB_EVENT ||
                       o_wb_data == `TEM_WB_TIMEOUT;
    endproperty
    a_wb_values: assert property (p_wb_values)
        else $error("bad writeback value");

    property p_no_wb_idle;
        @(posedge i_ref_clk) disable iff (i_rst)
        !any |=> !o_wb_valid;
    endproperty
    a_no_wb_idle: assert property (p_no_wb_idle)
        else $error("writeback without waiter");

    property p_hit_event;
        @(posedge i_ref_clk) disable iff (i_rst)
        grant_hit |=> o_wb_valid && o_wb_data == `TEM_WB_EVENT;
    endproperty
    a_hit_event: assert property (p_hit_event)
        else $error("event answered as timeout");

    property p_end_release;
        @(posedge i_ref_clk) disable iff (i_rst)
        is_end |=> o_release_valid && !o_active[$past(i_msg_tid)];
    endproperty
    a_end_release: assert property (p_end_release)
        else $error("thread not released");

    property p_one_grant;
        @(posedge i_ref_clk) disable iff (i_rst)
        $onehot0(grant) && (any == (grant != '0));
    endproperty
    a_one_grant: assert property (p_one_grant)
        else $error("bad writeback arbitration");

    sequence s_tid_grant;
        any ##0 grant[gtid];
    endsequence
    property p_wb_tid;
        @(posedge i_ref_clk) disable iff (i_rst)
        s_tid_grant |=> o_wb_tid == $past(gtid);
    endproperty
    a_wb_tid: assert property (p_wb_tid)
        else $error("writeback to wrong thread");
endmodule

// File: testbench/tem_fabric_model.sv
// Broadcast fabric model: loops own signals back, adds remote gateways
`timescale 1ns/1ps
module tem_fabric_model
    import tem_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Outbound from this gateway and from remote gateways
    input wire logic i_out_valid,
    input wire tem_pkg::tem_evid_t i_out_evid,
    input wire logic i_ext_valid,
    input wire tem_pkg::tem_evid_t i_ext_evid,
    // Inbound to this gateway
    output logic o_in_valid,
    output tem_pkg::tem_evid_t o_in_evid
);
    tem_evid_t last_q;
    assign o_in_valid = i_out_valid | i_ext_valid;
    assign o_in_evid = i_out_valid ? i_out_evid :
                       i_ext_valid ? i_ext_evid : ~last_q;
    // Idle id keeps toggling so a stale id is never mistaken for live
    always_ff @(posedge i_ref_clk) begin
        last_q <= o_in_evid;
    end
endmodule

// File: testbench/tem_gateway_tb_top.sv
// Self-checking bench for the event monitor gateway
`timescale 1ns/1ps
module tem_gateway_tb_top;
    import tem_pkg::*;
    logic clk, rst, mv, disp, pre, bo, bi, ext, wbv, relv;
    tem_op_t op;
    tem_tid_t tid, dtid, wbt, relt;
    tem_evid_t ev, boe, bie, exte;
    tem_tmo_t tmo;
    logic [31:0] wbd;
    logic [7:0] act;
    int fails = 0;
    int tests_run = 0;
    tem_gateway tem_gateway_i (.i_ref_clk(clk), .i_rst(rst),
        .i_msg_valid(mv), .i_msg_op(op), .i_msg_tid(tid),
        .i_msg_evid(ev), .i_msg_tmo(tmo), .i_dispatch(disp),
        .i_dispatch_tid(dtid), .i_preempt(pre), .o_bcast_valid(bo),
        .o_bcast_evid(boe), .i_bcast_valid(bi), .i_bcast_evid(bie),
        .o_wb_valid(wbv), .o_wb_tid(wbt), .o_wb_data(wbd),
        .o_active(act), .o_release_valid(relv), .o_release_tid(relt));
    tem_fabric_model tem_fabric_model_i (.i_ref_clk(clk),
        .i_out_valid(bo), .i_out_evid(boe), .i_ext_valid(ext),
        .i_ext_evid(exte), .o_in_valid(bi), .o_in_evid(bie));
    // ==========================================
    // Common tasks
    task automatic results();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One message per call; a gap cycle follows so valid is set once
    task automatic send(tem_op_t o, tem_tid_t t, tem_evid_t e,
                        tem_tmo_t m);
        @(posedge clk);
        mv <= 1'b1; op <= o; tid <= t; ev <= e; tmo <= m;
        @(posedge clk);
        mv <= 1'b0; op <= TEM_OP_NONE;
    endtask
    task automatic quiet(int n);
        repeat (n) begin
            @(posedge clk); #1;
            check(wbv, 1'b0);
        end
    endtask
    task automatic wait_wb(tem_tid_t t, logic [31:0] d, int n);
        repeat (n) begin
            @(posedge clk); #1;
            if (wbv === 1'b1) begin
                check(wbt, t);
                check(wbd, d);
                return;
            end
        end
        fails++;
        results();
    endtask
    // ==========================================
    // Scenarios
    task automatic sc_recorded_then_wait();
        send(TEM_OP_WATCH, 3'h1, 8'h05, 16'h0000);
        send(TEM_OP_SIGNAL, 3'h2, 8'h05, 16'h0000);
        quiet(5);
        send(TEM_OP_WAIT, 3'h1, 8'h05, 16'h03e8);
        wait_wb(3'h1, 32'h0000_0001, 3);
        send(TEM_OP_SIGNAL, 3'h2, 8'h05, 16'h0000);
        send(TEM_OP_SIGNAL, 3'h0, 8'h05, 16'h0000);
        quiet(3);
        send(TEM_OP_WAIT, 3'h1, 8'h05, 16'h03e8);
        wait_wb(3'h1, 32'h0000_0001, 3);
        send(TEM_OP_WAIT, 3'h1, 8'h05, 16'h0006);
        wait_wb(3'h1, 32'h0000_0000, 12);
    endtask
    task automatic sc_pending_then_signal();
        send(TEM_OP_WATCH, 3'h3, 8'h09, 16'h0000);
        send(TEM_OP_WAIT, 3'h3, 8'h09, 16'h03e8);
        quiet(6);
        send(TEM_OP_SIGNAL, 3'h0, 8'h09, 16'h0000);
        wait_wb(3'h3, 32'h0000_0001, 4);
        send(TEM_OP_WATCH, 3'h4, 8'h20, 16'h0000);
        send(TEM_OP_WAIT, 3'h4, 8'h20, 16'h03e8);
        @(posedge clk);
        ext <= 1'b1; exte <= 8'h20;
        @(posedge clk);
        ext <= 1'b0;
        #1;
        check(wbv, 1'b1);
        check(wbt, 3'h4);
        check(wbd, 32'h0000_0001);
    endtask
    task automatic sc_timeout_preempt();
        send(TEM_OP_WATCH, 3'h5, 8'h33, 16'h0000);
        send(TEM_OP_WAIT, 3'h5, 8'h33, 16'h0008);
        quiet(6);
        wait_wb(3'h5, 32'h0000_0000, 6);
        send(TEM_OP_WATCH, 3'h6, 8'h40, 16'h0000);
        send(TEM_OP_WAIT, 3'h6, 8'h40, 16'h03e8);
        @(posedge clk);
        pre <= 1'b1;
        @(posedge clk);
        pre <= 1'b0;
        #1;
        check(wbv, 1'b1);
        check(wbt, 3'h6);
        check(wbd, 32'h0000_0000);
    endtask
    task automatic sc_cancel_end();
        send(TEM_OP_CANCEL, 3'h1, 8'h05, 16'h0000);
        send(TEM_OP_SIGNAL, 3'h2, 8'h05, 16'h0000);
        send(TEM_OP_WAIT, 3'h1, 8'h05, 16'h0006);
        wait_wb(3'h1, 32'h0000_0000, 12);
        @(posedge clk);
        disp <= 1'b1; dtid <= 3'h7;
        @(posedge clk);
        disp <= 1'b0;
        @(posedge clk); #1;
        check(act[7], 1'b1);
        send(TEM_OP_WATCH, 3'h7, 8'h50, 16'h0000);
        send(TEM_OP_END, 3'h7, 8'h00, 16'h0000);
        #1;
        check(relv, 1'b1);
        check(relt, 3'h7);
        @(posedge clk); #1;
        check(act[7], 1'b0);
        send(TEM_OP_SIGNAL, 3'h0, 8'h50, 16'h0000);
        send(TEM_OP_WAIT, 3'h7, 8'h50, 16'h0006);
        wait_wb(3'h7, 32'h0000_0000, 12);
    endtask
    // ==========================================
    // Clock, reset and sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1; mv = 1'b0; op = TEM_OP_NONE; tid = 3'h0; ev = 8'h00;
        tmo = 16'h0000; disp = 1'b0; dtid = 3'h0; pre = 1'b0;
        ext = 1'b0; exte = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(wbv, 1'b0);
        check(act, 8'h00);
        sc_recorded_then_wait();
        sc_pending_then_signal();
        sc_timeout_preempt();
        sc_cancel_end();
        results();
    end
endmodule
